//--- hw/isp_cfg.svh
// isp_cfg.svh: register indices, field positions, reset values and codes
// assumes inclusion by the two sequencers and the top isp design module
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
// register indices; the bus byte address is four times the index
`define REG_ISP_CONTROL   8'hbf
`define REG_ARRAY_CONTROL 8'hc7
`define REG_ADDR_LOW      8'hc4
`define REG_ADDR_HIGH     8'hc5
`define REG_DATA_BYTE     8'hc6
`define REG_ISP_UNLOCK    8'hf6
`define REG_ISP_STATUS    8'hf8
// isp_control fields
`define ISPC_SOFT_REBOOT  7
`define ISPC_EXTRA_RAM    4
`define ISPC_LOADER_LOC   1
`define ISPC_PROG_EN      0
`define ISPC_STORE_MASK   8'h13
// array_control fields
`define ARRC_BANK         6
`define ARRC_OE           5
`define ARRC_CE           4
`define ARRC_STORE_MASK   8'h7f
// isp_status fields
`define STAT_DONE         3
// reset values
`define RST_BYTE          8'h00
// array operation codes
`define OP_READ           4'h0
`define OP_PROGRAM        4'h1
`define OP_ERASE          4'h2
// unlock keys
`define UNLOCK_KEY1       8'h87
`define UNLOCK_KEY2       8'h59
// cycles the strap synchroniser needs before its output is trusted
`define STRAP_SETTLE      2'h3
`endif

//--- hw/isp_pkg.sv
// isp_pkg.sv: state types of the isp register file and its helpers
// assumes every number comes from isp_cfg.svh
package isp_pkg;
  typedef enum logic [1:0] {st_locked, st_half, st_open} unlock_state_type;
  typedef struct packed {
    unlock_state_type state;
    logic             open;
  } unlock_regs_type;
  typedef enum logic {st_rest, st_busy} seq_state_type;
  typedef struct packed {
    seq_state_type state;
    logic          idle_d;
    logic          prog_mode;
    logic          done;
    logic          rd_done;
    logic          bank;
    logic          oe;
    logic          ce_n;
    logic [3:0]    op;
    logic [15:0]   addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
  } seq_regs_type;
  typedef struct packed {
    logic       waitreq;
    logic       reboot;
    logic       done_flag;
    logic       taken;
    logic       loader_boot;
    logic [1:0] settle;
    logic [1:0] strap_m;
    logic [1:0] strap_s;
    logic [7:0] rdata;
    logic [7:0] isp_ctl;
    logic [7:0] arr_ctl;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
  } top_regs_type;
endpackage

//--- hw/array_req_if.sv
// array_req_if.sv: request and answer between register file and sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface array_req_if;
  logic        prog_en;
  logic        bank;
  logic        oe;
  logic        ce;
  logic [3:0]  op;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        prog_mode;
  logic        busy;
  logic        done;
  logic        rd_done;
  logic [7:0]  rdata;
  modport regs (output prog_en, bank, oe, ce, op, addr, wdata,
                input  prog_mode, busy, done, rd_done, rdata);
  modport seq  (input  prog_en, bank, oe, ce, op, addr, wdata,
                output prog_mode, busy, done, rd_done, rdata);
endinterface

//--- hw/isp_unlock_seq.sv
// isp_unlock_seq.sv: two-key unlock of the isp control register
// assumes i_wr is a one-cycle strobe from the register file, same clock
`timescale 1ns/100ps
`include "isp_cfg.svh"
module isp_unlock_seq (
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst,   // async reset, high
  input  wire logic       i_clear, // soft reboot, one cycle
  input  wire logic       i_wr,    // write to the unlock register
  input  wire logic [7:0] i_wdata, // byte written
  output logic            o_open   // control register writable
);
  import isp_pkg::*;
  unlock_regs_type r_r;
  unlock_regs_type r_nxt;
  localparam unlock_regs_type UNLOCK_RST = '{state: st_locked, open: 1'b0};

  // key walk: any other byte closes the write window again
  always_comb begin
    r_nxt = r_r;
    if (i_wr) begin
      unique case (r_r.state)
        st_locked: r_nxt.state = (i_wdata == `UNLOCK_KEY1) ? st_half : st_locked;
        st_half: begin
          if (i_wdata == `UNLOCK_KEY2) r_nxt.state = st_open;
          else if (i_wdata == `UNLOCK_KEY1) r_nxt.state = st_half;
          else r_nxt.state = st_locked;
        end
        st_open: begin
          if (i_wdata != `UNLOCK_KEY1 && i_wdata != `UNLOCK_KEY2) r_nxt.state = st_locked;
        end
      endcase
    end
    if (i_clear) r_nxt.state = st_locked;
    r_nxt.open = (r_nxt.state == st_open);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) r_r <= UNLOCK_RST;
    else r_r <= r_nxt;
  end

  assign o_open = r_r.open;
endmodule

//--- hw/isp_array_seq.sv
// isp_array_seq.sv: programming-mode tracking and array operation timing
// assumes i_idle comes from the processor on the same clock
`timescale 1ns/100ps
`include "isp_cfg.svh"
module isp_array_seq (
  input  wire logic        i_clk,        // system clock
  input  wire logic        i_rst,        // async reset, high
  input  wire logic        i_clear,      // soft reboot, one cycle
  input  wire logic        i_idle,       // processor in idle mode
  input  wire logic [7:0]  i_array_rdata, // byte from the array
  array_req_if.seq         req,          // register side
  output logic             o_array_bank, // 1 loader bank
  output logic [3:0]       o_array_op,   // operation code
  output logic             o_array_oe,   // array output enable field
  output logic             o_array_ce_n, // array chip enable, low
  output logic [15:0]      o_array_addr, // target location
  output logic [7:0]       o_array_wdata // byte to program
);
  import isp_pkg::*;
  seq_regs_type r_r;
  seq_regs_type r_nxt;
  logic         idle_rise;
  logic         idle_fall;
  logic         op_ok;
  localparam seq_regs_type SEQ_RST = '{state: st_rest, ce_n: 1'b1, op: `OP_READ, default: '0};

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.rd_done = 1'b0;
    r_nxt.idle_d = i_idle;
    idle_rise = i_idle & ~r_r.idle_d;
    idle_fall = ~i_idle & r_r.idle_d;
    // only the three documented command words start the array
    op_ok = ((req.op == `OP_ERASE || req.op == `OP_PROGRAM) && req.oe) ||
            (req.op == `OP_READ && !req.oe);
    if (!req.prog_en) r_nxt.prog_mode = 1'b0;
    else if (idle_fall) r_nxt.prog_mode = 1'b1;
    unique case (r_r.state)
      st_rest: begin
        if (idle_rise && r_r.prog_mode && req.prog_en && !req.ce && op_ok) begin
          r_nxt.state = st_busy;
          r_nxt.op = req.op;
          r_nxt.bank = req.bank;
          r_nxt.oe = req.oe;
          r_nxt.ce_n = 1'b0;
          r_nxt.addr = req.addr;
          r_nxt.wdata = req.wdata;
        end
      end
      st_busy: begin
        if (!r_r.oe) r_nxt.rdata = i_array_rdata;
        // the wake-up ends the operation; software sizes the idle time
        if (idle_fall || !req.prog_en) begin
          r_nxt.state = st_rest;
          r_nxt.ce_n = 1'b1;
          r_nxt.done = 1'b1;
          r_nxt.rd_done = ~r_r.oe;
        end
      end
    endcase
    if (i_clear) r_nxt = SEQ_RST;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) r_r <= SEQ_RST;
    else r_r <= r_nxt;
  end

  assign req.prog_mode = r_r.prog_mode;
  assign req.busy = (r_r.state == st_busy);
  assign req.done = r_r.done;
  assign req.rd_done = r_r.rd_done;
  assign req.rdata = r_r.rdata;
  assign o_array_bank = r_r.bank;
  assign o_array_op = r_r.op;
  assign o_array_oe = r_r.oe;
  assign o_array_ce_n = r_r.ce_n;
  assign o_array_addr = r_r.addr;
  assign o_array_wdata = r_r.wdata;
endmodule

//--- hw/isp_program_memory_control.sv
// isp_program_memory_control.sv: register file and control of in-system
// programming for the on-chip main and loader code banks.
// assumes an Avalon-MM master on i_clk, a processor idle level on the same
// clock, and boot strap pins that may change at any time.
//
// Summary of operation
// - array_control bit 6 picks the target: 0 main bank, 1 loader bank
// - array_control bits 3:0 are the op code, bit 5 output enable, bit 4 chip enable
// - erase: op 0010, output enable 1, chip enable 0, bank from bit 6
// - program: op 0001, oe 1, ce 0, address and data byte used
// - read: op 0000, oe 0, ce 0; stored byte returns in data register
// - isp_control bit 7 written with bits 1 and 0 set reboots the device
// - isp_control bit 7 reads 1 while forced loader boot is active
// - isp_control bit 4 enables the auxiliary RAM
// - isp_control bit 1 selects where the loader runs
// - with bit 0 set, programming mode starts at wake from idle
// - bit 0 clear makes code memory read-only and blocks all operations
// - after power-on the device boots from the main bank by default
// - both boot straps low at power-up force loader boot
// - straps are sampled at reset; the system keeps them at safe levels
// - isp_control writable only after keys 87h then 59h to isp_unlock
// - high and low address registers form the target location
// - data register carries the byte to program or the byte read
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`include "isp_cfg.svh"
module isp_program_memory_control #(
  parameter int ADDR_W = 10                     // byte address width
) (
  input  wire logic              i_clk,              // 40 MHz clock
  input  wire logic              i_rst,              // async reset, high
  input  wire logic [ADDR_W-1:0] i_avs_address,      // byte address
  input  wire logic              i_avs_read,         // read request
  input  wire logic              i_avs_write,        // write request
  input  wire logic [31:0]       i_avs_writedata,    // write data
  input  wire logic [3:0]        i_avs_byteenable,   // byte lanes
  output logic [31:0]            o_avs_readdata,     // read data
  output logic                   o_avs_waitrequest,  // stall
  input  wire logic              i_cpu_idle,         // processor idle
  input  wire logic              i_strap_p26,        // boot strap pin a
  input  wire logic              i_strap_p27,        // boot strap pin b
  input  wire logic [7:0]        i_array_rdata,      // byte from array
  output logic                   o_array_bank,       // target bank
  output logic [3:0]             o_array_op,         // op code
  output logic                   o_array_oe,         // output enable
  output logic                   o_array_ce_n,       // chip enable
  output logic [15:0]            o_array_addr,       // target location
  output logic [7:0]             o_array_wdata,      // program byte
  output logic                   o_program_mode,     // isp mode on
  output logic                   o_soft_reboot,      // reboot pulse
  output logic                   o_extra_ram_enable, // aux RAM on
  output logic                   o_loader_location,  // loader placement
  output logic                   o_boot_from_loader  // forced boot
);
  import isp_pkg::*;

  top_regs_type r_r;
  top_regs_type r_nxt;
  logic         req_v;
  logic         acc;
  logic         wr_ok;
  logic [7:0]   wb;
  logic [7:0]   idx;
  logic [7:0]   rd_mux;
  logic         trig;
  logic         unlock_wr;
  logic         unlocked;
  logic         prog_mode_w;

  localparam top_regs_type TOP_RST = '{
    waitreq:     1'b1,
    isp_ctl:     `RST_BYTE,
    arr_ctl:     `RST_BYTE,
    addr_lo:     `RST_BYTE,
    addr_hi:     `RST_BYTE,
    data:        `RST_BYTE,
    rdata:       `RST_BYTE,
    default:     '0
  };

  // the decode below needs the top register at index f8h
  if (ADDR_W < 10) begin : g_addr_chk
    $error("ADDR_W must be at least 10");
  end

  array_req_if req ();

  // register fields that steer the sequencer
  // bank select drive
  assign req.bank = r_r.arr_ctl[`ARRC_BANK];
  assign req.op = r_r.arr_ctl[3:0];
  assign req.oe = r_r.arr_ctl[`ARRC_OE];
  assign req.ce = r_r.arr_ctl[`ARRC_CE];
  assign req.addr = {r_r.addr_hi, r_r.addr_lo};
  assign req.wdata = r_r.data;
  assign req.prog_en = r_r.isp_ctl[`ISPC_PROG_EN];

  isp_array_seq u_seq (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_clear       (r_r.reboot),
    .i_idle        (i_cpu_idle),
    .i_array_rdata (i_array_rdata),
    .req           (req.seq),
    .o_array_bank  (o_array_bank),
    .o_array_op    (o_array_op),
    .o_array_oe    (o_array_oe),
    .o_array_ce_n  (o_array_ce_n),
    .o_array_addr  (o_array_addr),
    .o_array_wdata (o_array_wdata)
  );

  isp_unlock_seq u_unlock (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (r_r.reboot),
    .i_wr    (unlock_wr),
    .i_wdata (wb),
    .o_open  (unlocked)
  );

  assign prog_mode_w = req.prog_mode;

  // bus decode; the request is answered one cycle after it is seen
  always_comb begin
    req_v = i_avs_read | i_avs_write;
    acc = req_v & ~r_r.waitreq;
    wr_ok = acc & i_avs_write & i_avs_byteenable[0];
    wb = i_avs_writedata[7:0];
    idx = i_avs_address[9:2];
    unlock_wr = wr_ok && (idx == `REG_ISP_UNLOCK);
    trig = wr_ok && unlocked && (idx == `REG_ISP_CONTROL) &&
           wb[`ISPC_SOFT_REBOOT] && wb[`ISPC_LOADER_LOC] && wb[`ISPC_PROG_EN];
  end

  // read data mux; unmapped indices read as zero
  always_comb begin
    case (idx)
      `REG_ISP_CONTROL: begin
        rd_mux = {r_r.loader_boot, 2'b00, r_r.isp_ctl[`ISPC_EXTRA_RAM], 2'b00,
                  r_r.isp_ctl[`ISPC_LOADER_LOC], r_r.isp_ctl[`ISPC_PROG_EN]};
      end
      `REG_ARRAY_CONTROL: begin
        rd_mux = {1'b0, r_r.arr_ctl[6:0]};
      end
      `REG_ADDR_LOW: begin
        rd_mux = r_r.addr_lo;
      end
      `REG_ADDR_HIGH: begin
        rd_mux = r_r.addr_hi;
      end
      `REG_DATA_BYTE: begin
        rd_mux = r_r.data;
      end
      `REG_ISP_UNLOCK: begin
        rd_mux = {7'h00, unlocked};
      end
      `REG_ISP_STATUS: begin
        rd_mux = {3'h0, r_r.loader_boot, r_r.done_flag, unlocked, req.busy, prog_mode_w};
      end
      default: begin
        rd_mux = `RST_BYTE;
      end
    endcase
  end

  // next state of the register file
  always_comb begin
    r_nxt = r_r;
    r_nxt.reboot = 1'b0;
    r_nxt.waitreq = ~(req_v & r_r.waitreq);
    // read data is prepared in the cycle that lowers waitrequest
    if (req_v && r_r.waitreq) begin
      r_nxt.rdata = rd_mux;
    end

    // software writes land only at the accepting edge
    if (wr_ok) begin
      case (idx)
        `REG_ISP_CONTROL: begin
          // bits 7, 3, 2 and reserved are not stored
          if (unlocked) begin
            r_nxt.isp_ctl = wb & `ISPC_STORE_MASK;
          end
        end
        `REG_ARRAY_CONTROL: begin
          r_nxt.arr_ctl = wb & `ARRC_STORE_MASK;
        end
        `REG_ADDR_LOW: begin
          r_nxt.addr_lo = wb;
        end
        `REG_ADDR_HIGH: begin
          r_nxt.addr_hi = wb;
        end
        `REG_DATA_BYTE: begin
          r_nxt.data = wb;
        end
        `REG_ISP_STATUS: begin
          if (wb[`STAT_DONE]) r_nxt.done_flag = 1'b0;
        end
        default: begin
          r_nxt.rdata = r_r.rdata;
        end
      endcase
    end

    // hardware updates follow software so that they win a tie
    if (req.done) begin
      r_nxt.done_flag = 1'b1;
    end
    if (req.rd_done) begin
      r_nxt.data = req.rdata;
    end

    // boot strap synchroniser; only the second stage is looked at
    r_nxt.strap_m = {i_strap_p27, i_strap_p26};
    r_nxt.strap_s = r_r.strap_m;
    if (!r_r.taken) begin
      if (r_r.settle != `STRAP_SETTLE) begin
        r_nxt.settle = r_r.settle + 2'h1;
      end else begin
        r_nxt.taken = 1'b1;
        r_nxt.loader_boot = (r_r.strap_s == 2'b00);
      end
    end

    if (trig) begin
      r_nxt.isp_ctl = `RST_BYTE;
      r_nxt.arr_ctl = `RST_BYTE;
      r_nxt.addr_lo = `RST_BYTE;
      r_nxt.addr_hi = `RST_BYTE;
      r_nxt.data = `RST_BYTE;
      r_nxt.done_flag = 1'b0;
      r_nxt.taken = 1'b0;
      r_nxt.settle = 2'h0;
      r_nxt.loader_boot = 1'b0;
      r_nxt.reboot = 1'b1;
    end
  end

  // all register file state in one register; the two sequencers keep their own
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r_r <= TOP_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from state
  assign o_avs_readdata = {24'h000000, r_r.rdata};
  assign o_avs_waitrequest = r_r.waitreq;
  assign o_soft_reboot = r_r.reboot;
  assign o_extra_ram_enable = r_r.isp_ctl[`ISPC_EXTRA_RAM];
  assign o_loader_location = r_r.isp_ctl[`ISPC_LOADER_LOC];
  assign o_boot_from_loader = r_r.loader_boot;
  assign o_program_mode = prog_mode_w;
endmodule

//--- test/isp_program_memory_control_assertions.sv
// isp_program_memory_control_assertions.sv: port checker of the isp block
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/100ps
module isp_checker #(
  parameter int ADDR_W = 10 // byte address width
) (
  input wire logic              i_clk,              // clock
  input wire logic              i_rst,              // async reset
  input wire logic [ADDR_W-1:0] i_avs_address,      // byte address
  input wire logic              i_avs_write,        // write request
  input wire logic [31:0]       i_avs_writedata,    // write data
  input wire logic              o_avs_waitrequest,  // stall
  input wire logic              i_cpu_idle,         // idle level
  input wire logic              o_array_bank,       // target bank
  input wire logic [3:0]        o_array_op,         // op code
  input wire logic              o_array_oe,         // output enable
  input wire logic              o_array_ce_n,       // chip enable
  input wire logic [15:0]       o_array_addr,       // location
  input wire logic [7:0]        o_array_wdata,      // program byte
  input wire logic              o_program_mode,     // isp mode
  input wire logic              o_soft_reboot,      // reboot pulse
  input wire logic              o_extra_ram_enable  // aux ram
);
  logic bus_wr;
  logic reboot_wr;
  // completed writes; the only legal causes of a control change
  assign bus_wr    = i_avs_write & ~o_avs_waitrequest;
  assign reboot_wr = bus_wr & (i_avs_address[9:2] == 8'hbf) & i_avs_writedata[7] & (&i_avs_writedata[1:0]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ce_needs_mode: assert property (
    !o_array_ce_n |-> o_program_mode) else $error("array enabled outside programming mode");
  a_ce_start_idle: assert property (
    $fell(o_array_ce_n) |-> $past(i_cpu_idle) && !$past(i_cpu_idle, 2))
    else $error("array operation began without an idle rise");
  a_ce_end_idle: assert property (
    !o_array_ce_n && !i_cpu_idle |=> o_array_ce_n) else $error("array still enabled after wake");
  a_op_legal: assert property (
    !o_array_ce_n |-> (o_array_op inside {4'h1, 4'h2} && o_array_oe) || (o_array_op == 4'h0 && !o_array_oe))
    else $error("illegal op and enable pair on the array");
  a_op_hold: assert property (
    !o_array_ce_n && !$past(o_array_ce_n) |-> $stable(o_array_op) && $stable(o_array_addr)
      && $stable(o_array_bank) && $stable(o_array_wdata)) else $error("array request moved mid operation");
  a_mode_entry: assert property (
    $rose(o_program_mode) |-> !$past(i_cpu_idle) && $past(i_cpu_idle, 2))
    else $error("programming mode entered without a wake from idle");
  a_reboot_cause: assert property (
    $rose(o_soft_reboot) |-> $past(reboot_wr) || $past(reboot_wr, 2))
    else $error("reboot pulse without a reboot write");
  a_reboot_single: assert property (
    o_soft_reboot |=> !o_soft_reboot) else $error("reboot pulse longer than one cycle");
  a_ram_change: assert property (
    $changed(o_extra_ram_enable) |-> $past(bus_wr) || $past(o_soft_reboot))
    else $error("aux ram enable changed with no write");
  c_read_op: cover property (!o_array_ce_n && o_array_op == 4'h0);
  c_erase_op: cover property (!o_array_ce_n && o_array_op == 4'h2);
  c_mode_on: cover property ($rose(o_program_mode));
  c_reboot: cover property (o_soft_reboot);
endmodule
bind isp_program_memory_control isp_checker #(.ADDR_W(ADDR_W)) u_isp_checker (
  .i_clk, .i_rst, .i_avs_address, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_cpu_idle,
  .o_array_bank, .o_array_op, .o_array_oe, .o_array_ce_n, .o_array_addr, .o_array_wdata,
  .o_program_mode, .o_soft_reboot, .o_extra_ram_enable
);

//--- test/code_array_model.sv
// code_array_model.sv: behavioural main and loader code banks
// assumes the array strobes of the isp block on the same clock
`timescale 1ns/100ps
module code_array_model (
  input  wire logic        i_clk,   // clock
  input  wire logic        i_bank,  // 1 loader bank
  input  wire logic [3:0]  i_op,    // op code
  input  wire logic        i_oe,    // output enable field
  input  wire logic        i_ce_n,  // chip enable, low
  input  wire logic [15:0] i_addr,  // location
  input  wire logic [7:0]  i_wdata, // byte to program
  output logic      [7:0]  o_rdata  // byte read
);
  logic [7:0] main_mem [int];
  logic [7:0] load_mem [int];
  // unwritten or erased locations read as all ones
  function automatic logic [7:0] fetch(input logic b, input logic [15:0] a);
    if (b)
      return load_mem.exists(int'(a)) ? load_mem[int'(a)] : 8'hff;
    return main_mem.exists(int'(a)) ? main_mem[int'(a)] : 8'hff;
  endfunction
  initial o_rdata = 8'h00;
  always @(posedge i_clk) begin
    if (!i_ce_n && i_oe && i_op == 4'h2) begin
      if (i_bank) load_mem.delete();
      else main_mem.delete();
    end
    if (!i_ce_n && i_oe && i_op == 4'h1) begin
      if (i_bank) load_mem[int'(i_addr)] = i_wdata;
      else main_mem[int'(i_addr)] = i_wdata;
    end
    // a released data bus toggles every cycle between its last byte and the inverse
    if (!i_ce_n && !i_oe && i_op == 4'h0) o_rdata <= fetch(i_bank, i_addr);
    else o_rdata <= ~o_rdata;
  end
endmodule

//--- test/isp_program_memory_control_tb.sv
// isp_program_memory_control_tb.sv: self-checking bench of the isp block
// assumes a behavioural code array on the far side and one 40 MHz clock
`timescale 1ns/100ps
module isp_program_memory_control_tb;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} reg_row_type;
  typedef struct packed {logic [7:0] ctl; logic [7:0] wd; logic [7:0] exp; logic ce_n;} op_row_type;
  logic        clk, rst, read, write, waitreq, cpu_idle, strap_a, strap_b;
  logic        arr_bank, arr_oe, ce_n, prog_mode, soft_reboot, ram_en, loader_loc, boot_loader;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, v;
  logic [7:0]  arr_rdata, arr_wdata;
  logic [3:0]  arr_op;
  logic [3:0]  lanes = 4'h1;
  logic [15:0] arr_addr;
  int          checks, miscompares, pulses;
  reg_row_type regs [7] = '{'{8'hc4, 8'h34, 8'h34}, '{8'hc5, 8'h12, 8'h12}, '{8'hc6, 8'ha7, 8'ha7},
    '{8'hc7, 8'h45, 8'h45}, '{8'hbf, 8'h13, 8'h00}, '{8'hf6, 8'h00, 8'h00}, '{8'h3e, 8'hff, 8'h00}};
  op_row_type  ops [6] = '{'{8'h61, 8'h5c, 8'h5c, 1'b0}, '{8'h21, 8'h5c, 8'h5c, 1'b0},
    '{8'h22, 8'h00, 8'h00, 1'b0}, '{8'h40, 8'h00, 8'h5c, 1'b0}, '{8'h00, 8'h00, 8'hff, 1'b0},
    '{8'h31, 8'h77, 8'h77, 1'b1}};
  isp_program_memory_control u_isp_program_memory_control (
    .i_clk(clk), .i_rst(rst), .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
    .i_avs_writedata(writedata), .i_avs_byteenable(lanes), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .i_cpu_idle(cpu_idle), .i_strap_p26(strap_a), .i_strap_p27(strap_b),
    .i_array_rdata(arr_rdata), .o_array_bank(arr_bank), .o_array_op(arr_op), .o_array_oe(arr_oe),
    .o_array_ce_n(ce_n), .o_array_addr(arr_addr), .o_array_wdata(arr_wdata), .o_program_mode(prog_mode),
    .o_soft_reboot(soft_reboot), .o_extra_ram_enable(ram_en), .o_loader_location(loader_loc),
    .o_boot_from_loader(boot_loader));
  code_array_model u_code_array_model (
    .i_clk(clk), .i_bank(arr_bank), .i_op(arr_op), .i_oe(arr_oe), .i_ce_n(ce_n),
    .i_addr(arr_addr), .i_wdata(arr_wdata), .o_rdata(arr_rdata));
  // clock and reboot pulse counter
  always #12.5 clk = ~clk;
  always @(posedge clk) if (soft_reboot === 1'b1) pulses++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access; held until waitrequest is seen low at an edge, a hang is left to the watchdog
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    read <= rd;
    write <= !rd;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic idle_go(input logic lvl, input int wait_n);
    @(posedge clk);
    cpu_idle <= lvl;
    repeat (wait_n) @(posedge clk);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  // main sequence; straps held high so no forced boot by accident
  initial begin
    {clk, read, write, cpu_idle, address, writedata} = '0;
    {rst, strap_a, strap_b} = 3'b111;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check({ce_n, prog_mode, boot_loader}, 3'b100);
    foreach (regs[i]) begin
      bus(0, regs[i].idx, regs[i].wd, v);
      bus(1, regs[i].idx, 8'h00, v);
      check(v, regs[i].exp);
    end
    $display("test register table finished");
    // a write with its low lane off is dropped
    lanes <= 4'h0;
    bus(0, 8'hc4, 8'hee, v);
    lanes <= 4'h1;
    bus(1, 8'hc4, 8'h00, v);
    check(v, 32'h34);
    bus(0, 8'hf6, 8'h87, v);
    bus(0, 8'hf6, 8'h59, v);
    // bits 3 and 2 written zero
    bus(0, 8'hbf, 8'h13, v);
    bus(1, 8'hbf, 8'h00, v);
    check(v, 32'h13);
    check({ram_en, loader_loc}, 2'b11);
    idle_go(1'b1, 3);
    idle_go(1'b0, 3);
    check(prog_mode, 1'b1);
    $display("test unlock and mode entry finished");
    foreach (ops[i]) begin
      bus(0, 8'hc6, ops[i].wd, v);
      bus(0, 8'hc7, ops[i].ctl, v);
      idle_go(1'b1, 3);
      check(ce_n, ops[i].ce_n);
      if (!ops[i].ce_n) begin
        check(arr_op, ops[i].ctl[3:0]);
        check({arr_bank, arr_oe}, ops[i].ctl[6:5]);
        check({arr_addr, arr_wdata}, {16'h1234, ops[i].wd});
      end
      idle_go(1'b0, 3);
      check(ce_n, 1'b1);
      bus(1, 8'hc6, 8'h00, v);
      check(v, ops[i].exp);
    end
    bus(1, 8'hf8, 8'h00, v);
    check(v, 32'h0d);
    bus(0, 8'hf8, 8'h08, v);
    bus(1, 8'hf8, 8'h00, v);
    check(v, 32'h05);
    $display("test array operations finished");
    bus(0, 8'hf6, 8'h00, v);
    bus(0, 8'hbf, 8'h00, v);
    bus(1, 8'hbf, 8'h00, v);
    check(v, 32'h13);
    bus(0, 8'hf6, 8'h87, v);
    bus(0, 8'hf6, 8'h59, v);
    bus(0, 8'hbf, 8'h10, v);
    // the control byte lands at this edge and the mode drops one edge later
    repeat (2) @(posedge clk);
    check({prog_mode, ram_en, loader_loc}, 3'b010);
    bus(0, 8'hc7, 8'h21, v);
    idle_go(1'b1, 3);
    check(ce_n, 1'b1);
    idle_go(1'b0, 3);
    $display("test relock and disable finished");
    bus(0, 8'hbf, 8'h81, v);
    repeat (4) @(posedge clk);
    check(pulses, 0);
    bus(0, 8'hbf, 8'h93, v);
    repeat (4) @(posedge clk);
    check(pulses, 1);
    bus(1, 8'hbf, 8'h00, v);
    check({v[7:0], ram_en}, 9'h000);
    $display("test soft reboot finished");
    {strap_a, strap_b} <= 2'b00;
    do_reset();
    check(boot_loader, 1'b1);
    bus(1, 8'hbf, 8'h00, v);
    check(v, 32'h80);
    {strap_a, strap_b} <= 2'b11;
    do_reset();
    check(boot_loader, 1'b0);
    $display("test forced boot finished");
    complete_run();
  end
endmodule
